// ---- src/shift_logic_alu.sv ----
// shift, rotate, nibble swap and bitwise logic slice of the 8-bit core
// assumes the decoder presents op and operand for one cycle with op_valid,
// and that the write-back path stores wb_data when wb_valid pulses
//
// Function
// - accumulator right shift puts 0 in bit 7 and old bit 0 in shifted_out, others kept.
// - accumulator right rotate puts old shifted_out in bit 7 and old bit 0 in shifted_out.
// - right shift and right rotate also work on a memory byte written back in place.
// - accumulator left shift puts 0 in bit 0 and old bit 7 in shifted_out, others kept.
// - accumulator left rotate puts old shifted_out in bit 0 and old bit 7 in shifted_out.
// - left shift and left rotate also work on a memory byte written back in place.
// - nibble swap exchanges the accumulator halves and leaves every flag alone.
// - AND with an immediate goes to the accumulator and updates only result_null.
// - AND with a memory byte goes to accumulator or memory and updates only result_null.
// - OR with an immediate goes to the accumulator and updates only result_null.
// - OR with a memory byte goes to accumulator or memory and updates only result_null.
// - XOR with an immediate goes to the accumulator and updates only result_null.
// - XOR with a memory byte goes to accumulator or memory and updates only result_null.
// - XOR into an I/O register writes the I/O register and changes no flag.
module shift_logic_alu
	import shift_logic_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              op_valid,
	input  wire op_t               op,
	input  wire logic [DATA_W-1:0] operand,
	input  wire logic              acc_load,
	input  wire logic [DATA_W-1:0] acc_load_data,
	input  wire logic              flags_load,
	input  wire flags_t            flags_load_data,
	output logic [DATA_W-1:0]      acc,
	output flags_t                 flags,
	output logic                   wb_valid,
	output dest_t                  wb_dest,
	output logic [DATA_W-1:0]      wb_data
);

	// every check below runs on the core clock and sleeps through reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ****************************************
	// state
	// ****************************************
	state_t s_q;
	state_t s_d;

	// ****************************************
	// next state
	// ****************************************
	// one op per cycle; loads from the core only act in idle cycles so an
	// op and a load in one cycle cannot fight over the accumulator
	always_comb begin
		logic [DATA_W-1:0] src;
		logic [DATA_W-1:0] res;
		logic              set_null;
		logic              to_acc;
		logic              to_mem;
		logic              to_io;
		src      = s_q.acc;
		res      = s_q.acc;
		set_null = 1'b0;
		to_acc   = 1'b0;
		to_mem   = 1'b0;
		to_io    = 1'b0;
		s_d          = s_q;
		s_d.wb_valid = 1'b0;
		if (op_valid) begin
			// memory shifts take the byte from the operand bus
			if (op == OP_SHR_M || op == OP_RRC_M || op == OP_SHL_M || op == OP_RLC_M) begin
				src = operand;
			end
			case (op)
				OP_SHR_A, OP_SHR_M: begin
					res                   = {1'b0, src[MSB_POS:1]};
					s_d.flags.shifted_out = src[LSB_POS];
				end
				// rotates read the flag as it stood before this op, so a chain acts as one wide shift
				OP_RRC_A, OP_RRC_M: begin
					res                   = {s_q.flags.shifted_out, src[MSB_POS:1]};
					s_d.flags.shifted_out = src[LSB_POS];
				end
				OP_SHL_A, OP_SHL_M: begin
					res                   = {src[MSB_POS-1:0], 1'b0};
					s_d.flags.shifted_out = src[MSB_POS];
				end
				OP_RLC_A, OP_RLC_M: begin
					res                   = {src[MSB_POS-1:0], s_q.flags.shifted_out};
					s_d.flags.shifted_out = src[MSB_POS];
				end
				OP_SWAP_A: begin
					res = {s_q.acc[3:0], s_q.acc[MSB_POS:4]};
				end
				OP_AND_AI, OP_AND_AM, OP_AND_MA: begin
					res      = s_q.acc & operand;
					set_null = 1'b1;
				end
				OP_OR_AI, OP_OR_AM, OP_OR_MA: begin
					res      = s_q.acc | operand;
					set_null = 1'b1;
				end
				OP_XOR_AI, OP_XOR_AM, OP_XOR_MA, OP_XOR_IOA: begin
					res      = s_q.acc ^ operand;
					set_null = (op != OP_XOR_IOA);
				end
				default: begin
					res = s_q.acc;
				end
			endcase
			// destination by operand order
			case (op)
				OP_SHR_M, OP_RRC_M, OP_SHL_M, OP_RLC_M: to_mem = 1'b1;
				OP_AND_MA, OP_OR_MA, OP_XOR_MA:         to_mem = 1'b1;
				OP_XOR_IOA:                             to_io  = 1'b1;
				default:                                to_acc = 1'b1;
			endcase
			// memory forms set result_null from the byte they write, not from acc
			if (set_null) begin
				s_d.flags.result_null = (res == ZERO_VAL);
			end
			if (to_acc) begin
				s_d.acc = res;
			end
			// io results leave on the memory path; wb_dest tells the sink which one
			if (to_mem || to_io) begin
				s_d.wb_valid = 1'b1;
				s_d.wb_dest  = to_io ? DEST_IO : DEST_MEM;
				s_d.wb_data  = res;
			end
		end else begin
			if (acc_load) begin
				s_d.acc = acc_load_data;
			end
			if (flags_load) begin
				s_d.flags = flags_load_data;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// the whole state clears at once, so no field can wake up stale
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state flops
	// wb_dest and wb_data hold between pulses; only wb_valid qualifies them
	assign acc      = s_q.acc;
	assign flags    = s_q.flags;
	assign wb_valid = s_q.wb_valid;
	assign wb_dest  = s_q.wb_dest;
	assign wb_data  = s_q.wb_data;

	// ****************************************
	// checks
	// ****************************************
	// one decoded op taken at this edge
	sequence s_take(op_t o);
		op_valid && op == o;
	endsequence

	// the three flags that shifts and rotates never touch
	sequence s_keep_nzw;
		flags.result_null == $past(flags.result_null)
		&& flags.nibble_carry == $past(flags.nibble_carry)
		&& flags.signed_wrap == $past(flags.signed_wrap);
	endsequence

	// a write-back pulse toward memory carrying v
	sequence s_mem_wb(logic [DATA_W-1:0] v);
		wb_valid && wb_dest == DEST_MEM && wb_data == v;
	endsequence

	// shifts and rotates: bit movement, the shifted-out flag and the untouched rest
	a_shr_acc: assert property (
		s_take(OP_SHR_A) |=> acc == {1'b0, $past(acc[MSB_POS:1])}
		&& flags.shifted_out == $past(acc[LSB_POS]) ##0 s_keep_nzw)
		else $error("acc right shift wrong");

	a_rrc_acc: assert property (
		s_take(OP_RRC_A) |=> acc == {$past(flags.shifted_out), $past(acc[MSB_POS:1])}
		&& flags.shifted_out == $past(acc[LSB_POS]) ##0 s_keep_nzw)
		else $error("acc right rotate wrong");

	a_shift_mem: assert property (
		s_take(OP_RRC_M) |=> s_mem_wb({$past(flags.shifted_out), $past(operand[MSB_POS:1])})
		##0 (acc == $past(acc) && flags.shifted_out == $past(operand[LSB_POS])))
		else $error("memory right rotate wrong");

	a_shl_acc: assert property (
		s_take(OP_SHL_A) |=> acc == {$past(acc[MSB_POS-1:0]), 1'b0}
		&& flags.shifted_out == $past(acc[MSB_POS]) ##0 s_keep_nzw)
		else $error("acc left shift wrong");

	a_rlc_acc: assert property (
		s_take(OP_RLC_A) |=> acc == {$past(acc[MSB_POS-1:0]), $past(flags.shifted_out)}
		&& flags.shifted_out == $past(acc[MSB_POS]) ##0 s_keep_nzw)
		else $error("acc left rotate wrong");

	a_shl_mem: assert property (
		s_take(OP_SHL_M) |=> s_mem_wb({$past(operand[MSB_POS-1:0]), 1'b0})
		##0 flags.shifted_out == $past(operand[MSB_POS]) ##0 $stable(acc))
		else $error("memory left shift wrong");

	a_swap_acc: assert property (
		s_take(OP_SWAP_A) |=> acc == {$past(acc[3:0]), $past(acc[MSB_POS:4])}
		&& $stable(flags))
		else $error("nibble swap wrong");

	// logic ops: result, destination and the null flag
	a_and_imm: assert property (
		s_take(OP_AND_AI) |=> acc == ($past(acc) & $past(operand)) && !wb_valid
		&& flags.shifted_out == $past(flags.shifted_out))
		else $error("and immediate wrong");

	a_and_mem: assert property (
		s_take(OP_AND_MA) |=> s_mem_wb($past(acc) & $past(operand)) ##0 $stable(acc))
		else $error("and into memory wrong");

	a_or_imm: assert property (
		s_take(OP_OR_AI) |=> acc == ($past(acc) | $past(operand))
		&& flags.signed_wrap == $past(flags.signed_wrap))
		else $error("or immediate wrong");

	a_or_mem: assert property (
		s_take(OP_OR_MA) |=> s_mem_wb($past(acc) | $past(operand)))
		else $error("or into memory wrong");

	a_xor_imm: assert property (
		s_take(OP_XOR_AI) |=> acc == ($past(acc) ^ $past(operand))
		&& flags.nibble_carry == $past(flags.nibble_carry))
		else $error("xor immediate wrong");

	a_xor_mem: assert property (
		s_take(OP_XOR_MA) |=> s_mem_wb($past(acc) ^ $past(operand)))
		else $error("xor into memory wrong");

	a_xor_io: assert property (
		s_take(OP_XOR_IOA) |=> wb_valid && wb_dest == DEST_IO
		&& wb_data == ($past(acc) ^ $past(operand)) && $stable(flags) && $stable(acc))
		else $error("xor into io wrong");

	a_null_flag: assert property (
		op_valid && (op == OP_AND_AM || op == OP_OR_AM || op == OP_XOR_AM)
		|=> flags.result_null == (acc == ZERO_VAL))
		else $error("null flag wrong");

	// memory forms of the shifts: byte on wb_data, acc and other flags untouched
	a_shr_mem: assert property (
		s_take(OP_SHR_M) |=> s_mem_wb({1'b0, $past(operand[MSB_POS:1])})
		##0 (flags.shifted_out == $past(operand[LSB_POS]) && $stable(acc)))
		else $error("memory right shift wrong");

	a_rlc_mem: assert property (
		s_take(OP_RLC_M)
		|=> s_mem_wb({$past(operand[MSB_POS-1:0]), $past(flags.shifted_out)})
		##0 flags.shifted_out == $past(operand[MSB_POS]))
		else $error("memory left rotate wrong");

	a_mem_keep: assert property (
		op_valid && op inside {OP_SHR_M, OP_RRC_M, OP_SHL_M, OP_RLC_M}
		|=> $stable(acc) ##0 s_keep_nzw)
		else $error("memory shift touched acc or flags");

	// memory operand into acc: result lands in acc, no write-back
	a_and_acc: assert property (
		s_take(OP_AND_AM) |=> acc == ($past(acc) & $past(operand)) && !wb_valid)
		else $error("and from memory wrong");

	a_or_acc: assert property (
		s_take(OP_OR_AM) |=> acc == ($past(acc) | $past(operand)) && !wb_valid)
		else $error("or from memory wrong");

	a_xor_acc: assert property (
		s_take(OP_XOR_AM) |=> acc == ($past(acc) ^ $past(operand)) && !wb_valid)
		else $error("xor from memory wrong");

	a_logic_keep: assert property (
		op_valid && op inside {[OP_AND_AI:OP_XOR_IOA]}
		|=> flags.shifted_out == $past(flags.shifted_out)
		&& flags.nibble_carry == $past(flags.nibble_carry)
		&& flags.signed_wrap == $past(flags.signed_wrap))
		else $error("logic op touched a carry flag");

	a_null_imm: assert property (
		op_valid && op inside {OP_AND_AI, OP_OR_AI, OP_XOR_AI}
		|=> flags.result_null == (acc == ZERO_VAL))
		else $error("null flag after immediate op wrong");

	a_null_mem: assert property (
		op_valid && op inside {OP_AND_MA, OP_OR_MA, OP_XOR_MA}
		|=> flags.result_null == (wb_data == ZERO_VAL))
		else $error("null flag after memory write wrong");

	// a write-back pulse only ever follows a memory or io form
	a_wb_pulse: assert property (
		wb_valid |-> $past(op_valid) && ($past(op) inside {OP_SHR_M, OP_RRC_M, OP_SHL_M,
		OP_RLC_M, OP_AND_MA, OP_OR_MA, OP_XOR_MA, OP_XOR_IOA}))
		else $error("write-back without a memory or io op");

endmodule

// ---- src/shift_logic_pkg.sv ----
// types and constants for the shift and logic datapath slice
// assumes one core clock and an instruction decoder that issues one op per cycle
package shift_logic_pkg;

	// ****************************************
	// widths and bit positions
	// ****************************************
	localparam int DATA_W  = 8;
	localparam int MSB_POS = 7;
	localparam int LSB_POS = 0;

	// ****************************************
	// flags
	// ****************************************
	typedef struct packed {
		logic result_null;
		logic shifted_out;
		logic nibble_carry;
		logic signed_wrap;
	} flags_t;

	localparam flags_t FLAGS_RST = 4'h0;
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;

	// ****************************************
	// operations and write-back targets
	// ****************************************
	typedef enum logic [4:0] {
		OP_SHR_A, OP_RRC_A, OP_SHR_M, OP_RRC_M,
		OP_SHL_A, OP_RLC_A, OP_SHL_M, OP_RLC_M,
		OP_SWAP_A,
		OP_AND_AI, OP_AND_AM, OP_AND_MA,
		OP_OR_AI, OP_OR_AM, OP_OR_MA,
		OP_XOR_AI, OP_XOR_AM, OP_XOR_MA, OP_XOR_IOA
	} op_t;

	typedef enum logic {
		DEST_MEM,
		DEST_IO
	} dest_t;

	// ****************************************
	// whole block state
	// ****************************************
	typedef struct packed {
		logic [DATA_W-1:0] acc;
		flags_t            flags;
		logic              wb_valid;
		dest_t             wb_dest;
		logic [DATA_W-1:0] wb_data;
	} state_t;

	localparam state_t STATE_RST = {ACC_RST, FLAGS_RST, 1'b0, DEST_MEM, ZERO_VAL};

endpackage

// ---- tb/wb_sink.sv ----
// far-side model: data memory byte and io output latch fed by write-back
// assumes wb_valid is a one-cycle pulse qualified by wb_dest
module wb_sink
	import shift_logic_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              wb_valid,
	input  wire dest_t             wb_dest,
	input  wire logic [DATA_W-1:0] wb_data,
	output logic [DATA_W-1:0]      mem_q,
	output logic [DATA_W-1:0]      io_q
);
	timeunit 1ns;
	timeprecision 1ps;

	// store only on the pulse, so a stale wb_data can never leak in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_q <= 8'h00;
			io_q <= 8'h00;
		end else if (wb_valid) begin
			if (wb_dest == DEST_IO)
				io_q <= wb_data;
			else
				mem_q <= wb_data;
		end
	end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the shift and logic slice
// assumes one op per cycle, results one cycle after the taking edge
module tb
	import shift_logic_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// signals and expected state
	// ****************************************
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              op_valid = 1'b0;
	op_t               op = OP_SHR_A;
	logic [7:0]        operand = 8'h00;
	logic              acc_load = 1'b0;
	logic [7:0]        acc_load_data = 8'h00;
	logic              flags_load = 1'b0;
	flags_t            flags_load_data = 4'h0;
	logic [7:0]        acc, wb_data, mem_q, io_q;
	flags_t            flags;
	logic              wb_valid;
	dest_t             wb_dest;
	logic [7:0]        e_acc = 8'h00, e_dat = 8'h00, e_mem = 8'h00, e_io = 8'h00;
	flags_t            e_flg = 4'h0;
	logic              e_wbv = 1'b0;
	dest_t             e_dst = DEST_MEM;
	integer            seed = 63;
	integer            n_errors = 0;
	integer            checks = 0;

	always #12.5 clk = ~clk;

	shift_logic_alu i_shift_logic_alu (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
		.op(op), .operand(operand), .acc_load(acc_load), .acc_load_data(acc_load_data),
		.flags_load(flags_load), .flags_load_data(flags_load_data), .acc(acc),
		.flags(flags), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data));
	wb_sink i_wb_sink (.clk(clk), .rst_n(rst_n), .wb_valid(wb_valid), .wb_dest(wb_dest),
		.wb_data(wb_data), .mem_q(mem_q), .io_q(io_q));

	// ****************************************
	// reference model and checks
	// ****************************************
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// next expected state from the inputs the coming edge samples
	function automatic void apply(logic v, op_t o, logic [7:0] d, logic al, logic [7:0] ad,
		logic fl, flags_t fd);
		logic       mem_op;
		logic [7:0] s;
		logic [7:0] r;
		mem_op = o inside {OP_SHR_M, OP_RRC_M, OP_SHL_M, OP_RLC_M, OP_AND_MA, OP_OR_MA, OP_XOR_MA};
		s = (o inside {OP_SHR_M, OP_RRC_M, OP_SHL_M, OP_RLC_M}) ? d : e_acc;
		if (e_wbv && e_dst == DEST_IO)
			e_io = e_dat;
		else if (e_wbv)
			e_mem = e_dat;
		e_wbv = 1'b0;
		if (!v) begin
			if (al)
				e_acc = ad;
			if (fl)
				e_flg = fd;
			return;
		end
		// codes past the last op do nothing; loads beside them stay ignored
		if (o > OP_XOR_IOA)
			return;
		r = 8'h00;
		case (o)
			OP_SHR_A, OP_SHR_M: r = {1'b0, s[7:1]};
			OP_RRC_A, OP_RRC_M: r = {e_flg.shifted_out, s[7:1]};
			OP_SHL_A, OP_SHL_M: r = {s[6:0], 1'b0};
			OP_RLC_A, OP_RLC_M: r = {s[6:0], e_flg.shifted_out};
			OP_SWAP_A: r = {s[3:0], s[7:4]};
			OP_AND_AI, OP_AND_AM, OP_AND_MA: r = s & d;
			OP_OR_AI, OP_OR_AM, OP_OR_MA: r = s | d;
			default: r = s ^ d;
		endcase
		if (o inside {OP_SHR_A, OP_SHR_M, OP_RRC_A, OP_RRC_M})
			e_flg.shifted_out = s[0];
		else if (o inside {OP_SHL_A, OP_SHL_M, OP_RLC_A, OP_RLC_M})
			e_flg.shifted_out = s[7];
		else if (o != OP_SWAP_A && o != OP_XOR_IOA)
			e_flg.result_null = (r == 8'h00);
		if (mem_op || o == OP_XOR_IOA) begin
			e_wbv = 1'b1;
			e_dst = (o == OP_XOR_IOA) ? DEST_IO : DEST_MEM;
			e_dat = r;
		end else
			e_acc = r;
	endfunction

	// drive one cycle; checks the result of the previous cycle's inputs
	task automatic step(input logic v, input op_t o, input logic [7:0] d, input logic al,
		input logic [7:0] ad, input logic fl, input flags_t fd);
		@(posedge clk);
		op_valid <= v;
		op <= o;
		operand <= d;
		acc_load <= al;
		acc_load_data <= ad;
		flags_load <= fl;
		flags_load_data <= fd;
		@(negedge clk);
		chk("acc", acc, e_acc);
		chk("flags", {4'h0, flags}, {4'h0, e_flg});
		chk("wb_valid", {7'h0, wb_valid}, {7'h0, e_wbv});
		if (e_wbv)
			chk("wb_data", wb_data, e_dat);
		if (e_wbv)
			chk("wb_dest", {7'h0, wb_dest}, {7'h0, e_dst});
		chk("mem", mem_q, e_mem);
		chk("io", io_q, e_io);
		apply(v, o, d, al, ad, fl, fd);
	endtask

	// mid-run reset: async clear of every output and of the far-side latches
	task automatic pulse_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		op_valid <= 1'b0;
		acc_load <= 1'b0;
		flags_load <= 1'b0;
		@(negedge clk);
		chk("rst acc", acc, 8'h00);
		chk("rst flags", {4'h0, flags}, 8'h00);
		chk("rst wb_valid", {7'h0, wb_valid}, 8'h00);
		chk("rst wb_dest", {7'h0, wb_dest}, 8'h00);
		chk("rst wb_data", wb_data, 8'h00);
		chk("rst mem", mem_q, 8'h00);
		chk("rst io", io_q, 8'h00);
		e_acc = 8'h00;
		e_flg = 4'h0;
		e_wbv = 1'b0;
		e_mem = 8'h00;
		e_io = 8'h00;
		@(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************
	// sequence and watchdog
	// ****************************************
	// about 2040 one-cycle steps are planned; 3000 cycles leave a wide margin
	initial begin
		#(25 * 3000);
		n_errors++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// corners: preset carry, loads ignored beside an op, zero result
		step(0, OP_SHR_A, 8'h00, 0, 8'h00, 1, 4'h4);
		step(1, OP_SHR_M, 8'h81, 0, 8'h00, 0, 4'h0);
		step(1, OP_RRC_A, 8'h00, 1, 8'hff, 1, 4'hf);
		step(0, OP_SHR_A, 8'h00, 1, 8'hf0, 0, 4'h0);
		step(1, OP_AND_AI, 8'h0f, 0, 8'h00, 0, 4'h0);
		step(1, OP_XOR_IOA, 8'h5a, 0, 8'h00, 0, 4'h0);
		step(1, op_t'(5'h1f), 8'h33, 1, 8'h77, 1, 4'hf);
		for (int i = 0; i < 19; i++)
			step(1, op_t'(5'(i)), 8'($random(seed)), 0, 8'h00, 0, 4'h0);
		$display("directed test done");
		pulse_reset();
		$display("reset test done");
		for (int i = 0; i < 2000; i++)
			step(($random(seed) & 3) != 0, op_t'(5'($unsigned($random(seed)) % 19)),
				8'($random(seed)), 1'($random(seed)), 8'($random(seed)),
				1'($random(seed)), 4'($random(seed)));
		step(0, OP_SHR_A, 8'h00, 0, 8'h00, 0, 4'h0);
		step(0, OP_SHR_A, 8'h00, 0, 8'h00, 0, 4'h0);
		$display("random test done");
		finish_test();
	end
endmodule
